// ===== design/fca_top.sv
// Local design decisions: the address map and register access over APB.
`include "fca_defines.svh"

module fca_fifo #(
    parameter int W = 32,
    parameter int D = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         wr_valid,
    output logic              wr_ready,
    input  wire logic [W-1:0] wr_data,
    output logic              rd_valid,
    input  wire logic         rd_ready,
    output logic [W-1:0]      rd_data
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0]   cnt_r;
    logic          push;
    logic          pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(D - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    assign wr_ready = (cnt_r != (PW+1)'(D));
    assign rd_valid = (cnt_r != '0);
    assign rd_data  = mem[rp_r];
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_r] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= bump(wp_r);
            end
            if (pop) begin
                rp_r <= bump(rp_r);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : fca_fifo

module fca_top
    import fca_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [`FCA_AW-1:0]  paddr,
    input  wire logic [`FCA_DW-1:0]  pwdata,
    output logic                     pready,
    output logic [`FCA_DW-1:0]       prdata,
    output logic                     pslverr,
    input  wire logic                in_valid,
    output logic                     in_ready,
    input  wire logic [`FCA_DW-1:0]  in_data,
    input  wire logic                in_last,
    output logic                     out_valid,
    input  wire logic                out_ready,
    output logic [`FCA_DW-1:0]       out_data,
    output logic                     out_last,
    input  wire logic                trig_in,
    input  wire logic                line1_in,
    input  wire logic                line2_in,
    output logic                     payload_kind
);
    logic                    master_r;
    logic                    fcnt_en_r;
    logic [1:0]              chunk_sel_r;
    logic [1:0]              slot_r;
    logic [1:0]              evt_r;
    fca_clr_origin_t         org_r;
    logic [`FCA_DW-1:0]      roi_r [`FCA_ROI_WORDS];
    logic [`FCA_DW-1:0]      fcnt_r;
    logic [`FCA_DW-1:0]      fsnap_r;
    logic [`FCA_DW-1:0]      tcnt_r;
    logic                    sw_clr_r;
    logic [2:0]              l1_r;
    logic [2:0]              l2_r;
    logic                    trig_q_r;
    logic                    sof_r;
    fca_state_t              st_r;
    logic [2:0]              idx_r;
    logic                    wr_acc;
    logic                    line_clr;
    logic                    frame_go;
    logic                    push_valid;
    logic                    push_ready;
    logic [`FCA_DW:0]        push_word;
    logic [`FCA_DW:0]        pop_word;
    logic [`FCA_DW-1:0]      rd_mux;
    logic                    rd_err;
    logic                    fifo_rd_valid;
    logic                    fifo_rd_ready;

    function automatic logic roi_hit(input logic [`FCA_AW-1:0] a);
        roi_hit = (a >= `FCA_ADR_ROI) && (a <= `FCA_ADR_ROI_END);
    endfunction : roi_hit

    function automatic logic [2:0] roi_idx(input logic [`FCA_AW-1:0] a);
        logic [`FCA_AW-1:0] d;
        d = a - `FCA_ADR_ROI;
        roi_idx = d[4:2];
    endfunction : roi_idx

    assign wr_acc = psel && penable && pready && pwrite;

    // read mux, resolved in the setup cycle and registered for the access phase
    always_comb begin
        rd_mux = '0;
        rd_err = 1'b0;
        if (paddr == `FCA_ADR_CTRL) begin
            rd_mux[0] = master_r;
        end else if (paddr == `FCA_ADR_SEL) begin
            rd_mux[1:0] = chunk_sel_r;
        end else if (paddr == `FCA_ADR_EN) begin
            rd_mux[0] = (chunk_sel_r == `FCA_SEL_FCNT) ? fcnt_en_r : master_r;
        end else if (paddr == `FCA_ADR_SLOT) begin
            rd_mux[3:0] = {evt_r, slot_r};
        end else if (paddr == `FCA_ADR_CLR_ORG) begin
            rd_mux[1:0] = org_r;
        end else if (paddr == `FCA_ADR_CLR_CMD) begin
            rd_mux = '0;
        end else if (paddr == `FCA_ADR_FCNT) begin
            rd_mux = fcnt_r;
        end else if (paddr == `FCA_ADR_PAYLOAD) begin
            rd_mux[0] = master_r;
        end else if (roi_hit(paddr)) begin
            rd_mux = roi_r[roi_idx(paddr)];
        end else if (paddr == `FCA_ADR_TCNT) begin
            rd_mux = tcnt_r;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && rd_err;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // chunk mode control
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            master_r    <= 1'b0;
            fcnt_en_r   <= 1'b0;
            chunk_sel_r <= '0;
        end else if (wr_acc) begin
            if (paddr == `FCA_ADR_CTRL) begin
                master_r <= pwdata[0];
                if (!pwdata[0]) begin
                    fcnt_en_r <= 1'b0;
                end
            end else if (paddr == `FCA_ADR_SEL) begin
                chunk_sel_r <= pwdata[1:0];
            end else if (paddr == `FCA_ADR_EN) begin
                if (master_r && chunk_sel_r == `FCA_SEL_FCNT) begin
                    fcnt_en_r <= pwdata[0];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            payload_kind <= 1'b0;
        end else begin
            payload_kind <= master_r;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `FCA_ROI_WORDS; i++) begin
                roi_r[i] <= '0;
            end
        end else if (wr_acc && roi_hit(paddr)) begin
            roi_r[roi_idx(paddr)] <= pwdata;
        end
    end

    // counter slot and clear origin
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            slot_r   <= '0;
            evt_r    <= '0;
            org_r    <= FCA_ORG_OFF;
            sw_clr_r <= 1'b0;
        end else begin
            sw_clr_r <= 1'b0;
            if (wr_acc && paddr == `FCA_ADR_SLOT) begin
                slot_r <= pwdata[1:0];
                evt_r  <= pwdata[3:2];
            end
            // origin belongs to the frame counter slot only
            if (wr_acc && paddr == `FCA_ADR_CLR_ORG &&
                slot_r == `FCA_SLOT_SECOND && evt_r == `FCA_EVT_FBEGIN) begin
                org_r <= fca_clr_origin_t'(pwdata[1:0]);
            end
            if (wr_acc && paddr == `FCA_ADR_CLR_CMD && pwdata[0]) begin
                sw_clr_r <= (org_r == FCA_ORG_SW);
            end
        end
    end

    // line inputs: two-flop sync then edge stage
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            l1_r <= '0;
            l2_r <= '0;
        end else begin
            l1_r <= {l1_r[1:0], line1_in};
            l2_r <= {l2_r[1:0], line2_in};
        end
    end

    assign line_clr = (org_r == FCA_ORG_LINE1 && l1_r[1] && !l1_r[2]) ||
                      (org_r == FCA_ORG_LINE2 && l2_r[1] && !l2_r[2]);

    // frame begins with the first accepted word after reset or a last word
    assign frame_go = (st_r == FCA_ST_PASS) && in_valid && in_ready && sof_r;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fcnt_r  <= `FCA_CNT_ZERO;
            fsnap_r <= `FCA_CNT_ZERO;
        end else begin
            if (frame_go) begin
                fsnap_r <= fcnt_r;
            end
            if (line_clr || sw_clr_r) begin
                fcnt_r <= `FCA_CNT_ZERO;
            end else if (frame_go) begin
                // counts at frame start, so frames lost later still use a number
                fcnt_r <= fcnt_r + `FCA_CNT_ONE;
            end
        end
    end

    // trigger counter reads one after its first trigger
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            trig_q_r <= 1'b0;
            tcnt_r   <= `FCA_CNT_ZERO;
        end else begin
            trig_q_r <= trig_in;
            if (trig_in && !trig_q_r) begin
                tcnt_r <= tcnt_r + `FCA_CNT_ONE;
            end
        end
    end

    // framer: pass image, then append chunk words
    always_comb begin
        push_valid = 1'b0;
        push_word  = '0;
        in_ready   = 1'b0;
        case (st_r)
            FCA_ST_PASS: begin
                push_valid = in_valid;
                in_ready   = push_ready;
                push_word  = {in_last && !master_r, in_data};
            end
            FCA_ST_EXT: begin
                push_valid = 1'b1;
                push_word  = {idx_r == 3'(`FCA_ROI_WORDS - 1) && !fcnt_en_r, roi_r[idx_r]};
            end
            FCA_ST_FCNT: begin
                push_valid = 1'b1;
                push_word  = {1'b1, fsnap_r};
            end
            default: begin
                push_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_r  <= FCA_ST_PASS;
            idx_r <= '0;
            sof_r <= 1'b1;
        end else begin
            case (st_r)
                FCA_ST_PASS: begin
                    if (in_valid && in_ready) begin
                        sof_r <= in_last;
                        if (in_last && master_r) begin
                            st_r  <= FCA_ST_EXT;
                            idx_r <= '0;
                        end
                    end
                end
                FCA_ST_EXT: begin
                    if (push_ready) begin
                        idx_r <= idx_r + 1'b1;
                        if (idx_r == 3'(`FCA_ROI_WORDS - 1)) begin
                            st_r <= fcnt_en_r ? FCA_ST_FCNT : FCA_ST_PASS;
                        end
                    end
                end
                FCA_ST_FCNT: begin
                    if (push_ready) begin
                        st_r <= FCA_ST_PASS;
                    end
                end
                default: begin
                    st_r <= FCA_ST_PASS;
                end
            endcase
        end
    end

    fca_fifo #(
        .W (`FCA_DW + 1),
        .D (`FCA_FIFO_DEPTH)
    ) fca_fifo_i (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .wr_valid (push_valid),
        .wr_ready (push_ready),
        .wr_data  (push_word),
        .rd_valid (fifo_rd_valid),
        .rd_ready (fifo_rd_ready),
        .rd_data  (pop_word)
    );

    assign fifo_rd_ready = !out_valid || out_ready;

    // output stage keeps the stream pins on flops; the fifo refills it as the host takes words
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
            out_last  <= 1'b0;
        end else begin
            if (fifo_rd_valid && fifo_rd_ready) begin
                out_valid <= 1'b1;
                out_data  <= pop_word[`FCA_DW-1:0];
                out_last  <= pop_word[`FCA_DW];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule : fca_top

// ===== design/fca_defines.svh
`ifndef FCA_DEFINES_SVH
`define FCA_DEFINES_SVH
`define FCA_DW           32
`define FCA_AW           8
`define FCA_FIFO_DEPTH   4
`define FCA_ROI_WORDS    8
`define FCA_ADR_CTRL     8'h00
`define FCA_ADR_SEL      8'h04
`define FCA_ADR_EN       8'h08
`define FCA_ADR_SLOT     8'h0C
`define FCA_ADR_CLR_ORG  8'h10
`define FCA_ADR_CLR_CMD  8'h14
`define FCA_ADR_FCNT     8'h18
`define FCA_ADR_PAYLOAD  8'h1C
`define FCA_ADR_ROI      8'h20
`define FCA_ADR_ROI_END  8'h3C
`define FCA_ADR_TCNT     8'h40
`define FCA_SEL_FCNT     2'h1
`define FCA_SLOT_SECOND  2'h2
`define FCA_EVT_FBEGIN   2'h1
`define FCA_CNT_ZERO     32'h0000_0000
`define FCA_CNT_ONE      32'h0000_0001
`endif

// ===== design/fca_pkg.sv
package fca_pkg;
    typedef enum logic [1:0] {
        FCA_ORG_OFF,
        FCA_ORG_LINE1,
        FCA_ORG_LINE2,
        FCA_ORG_SW
    } fca_clr_origin_t;
    typedef enum logic [1:0] {
        FCA_ST_PASS,
        FCA_ST_EXT,
        FCA_ST_FCNT
    } fca_state_t;
endpackage : fca_pkg

// ===== dv/fca_monitor.sv
`include "fca_defines.svh"

module fca_monitor (
    input wire logic               clk_sys,
    input wire logic               sys_rst,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [`FCA_AW-1:0] paddr,
    input wire logic [`FCA_DW-1:0] pwdata,
    input wire logic               pready,
    input wire logic [`FCA_DW-1:0] prdata,
    input wire logic               pslverr,
    input wire logic               in_valid,
    input wire logic               in_ready,
    input wire logic               in_last,
    input wire logic               out_valid,
    input wire logic               out_ready,
    input wire logic [`FCA_DW-1:0] out_data,
    input wire logic               out_last,
    input wire logic               payload_kind
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence ctrl_wr_s;
        psel && penable && pready && pwrite && paddr == `FCA_ADR_CTRL;
    endsequence
    sequence img_end_s;
        in_valid && in_ready && in_last && payload_kind;
    endsequence
    chk_ready_next: assert property (setup_s |=> pready) else $error("no pready after setup");
    chk_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    chk_ready_single: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    chk_unmapped_err: assert property (setup_s ##0 paddr > `FCA_ADR_TCNT |=> pslverr && (pwrite || prdata == '0))
        else $error("unmapped access not refused");
    chk_payload_follow: assert property (ctrl_wr_s |=> ##1 payload_kind == $past(pwdata[0], 2))
        else $error("payload kind does not follow master switch");
    chk_chunk_gap: assert property (img_end_s |=> !in_ready [*8])
        else $error("input taken during chunk append");
    chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
        else $error("output word dropped while stalled");
    chk_idle_rst: assert property ($fell(sys_rst) |-> in_ready && !out_valid && !payload_kind)
        else $error("not idle after reset");
endmodule : fca_monitor

// ===== dv/fca_host_model.sv
module fca_host_model (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        slow,
    input wire logic        out_valid,
    output logic            out_ready,
    input wire logic [31:0] out_data,
    input wire logic        out_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] got[$];
    int          last_at;
    int          frames;
    logic [1:0]  tick_r;
    // slow host accepts one word in two
    assign out_ready = !slow || tick_r[0];
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            tick_r <= 2'h0;
        else
            tick_r <= tick_r + 2'h1;
    end
    always @(posedge clk_sys) begin
        if (out_valid && out_ready) begin
            got.push_back(out_data);
            if (out_last) begin
                last_at = got.size() - 1;
                frames++;
            end
        end
    end
endmodule : fca_host_model

// ===== dv/tb_fca_top.sv
`include "fca_defines.svh"

module tb_fca_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, slow;
    logic               in_valid, in_ready, in_last, out_valid, out_ready, out_last;
    logic               trig_in, line1_in, line2_in, payload_kind;
    logic [`FCA_AW-1:0] paddr;
    logic [31:0]        pwdata, prdata, in_data, out_data;
    int                 fail_count, num_checks, cycles;

    fca_top fca_top_i (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .in_valid, .in_ready, .in_data, .in_last, .out_valid, .out_ready, .out_data, .out_last,
        .trig_in, .line1_in, .line2_in, .payload_kind);
    fca_host_model fca_host_model_i (.clk_sys, .sys_rst, .slow, .out_valid, .out_ready, .out_data, .out_last);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input string nm, input logic [31:0] x, input logic [31:0] s);
        num_checks++;
        if (s !== x) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(nm, x, q);
    endtask : rd

    task automatic pulse(input int l);
        if (l == 1)
            line1_in <= 1'b1;
        else if (l == 2)
            line2_in <= 1'b1;
        else
            trig_in <= 1'b1;
        repeat (2) @(posedge clk_sys);
        {line1_in, line2_in, trig_in} <= 3'h0;
        repeat (4) @(posedge clk_sys);
    endtask : pulse

    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            in_valid <= 1'b1;
            in_data  <= 32'hA000_0000 + i;
            in_last  <= (i == n - 1);
            do @(posedge clk_sys); while (in_ready !== 1'b1);
        end
        in_valid <= 1'b0;
        in_last  <= 1'b0;
        in_data  <= ~in_data;
    endtask : send

    // k words expected: 2 image, 8 roi, then counter word c
    task automatic t_frame(input int k, input logic [31:0] c);
        int f;
        int n;
        f = fca_host_model_i.frames;
        send(2);
        for (n = 0; n < 500 && fca_host_model_i.frames == f; n++) @(posedge clk_sys);
        check("words", k, fca_host_model_i.got.size());
        check("last_at", k - 1, fca_host_model_i.last_at);
        for (n = 0; n < k; n++)
            check("word", n < 2 ? 32'hA000_0000 + n : n < 10 ? 32'h100 + n - 2 : c, fca_host_model_i.got[n]);
        fca_host_model_i.got.delete();
        $display("frame of %0d words done", k);
    endtask : t_frame

    task automatic t_setup();
        rd(`FCA_ADR_PAYLOAD, 32'h0, "payload_rst");
        rd(`FCA_ADR_CLR_ORG, 32'h0, "org_rst");
        rd(`FCA_ADR_FCNT, 32'h0, "fcnt_rst");
        wr(`FCA_ADR_SEL, 32'(`FCA_SEL_FCNT));
        wr(`FCA_ADR_EN, 32'h1);
        rd(`FCA_ADR_EN, 32'h0, "en_locked");
        wr(`FCA_ADR_CTRL, 32'h1);
        rd(`FCA_ADR_PAYLOAD, 32'h1, "payload_on");
        check("payload_pin", 32'h1, payload_kind);
        wr(`FCA_ADR_SEL, 32'h0);
        rd(`FCA_ADR_EN, 32'h1, "ext_auto");
        wr(`FCA_ADR_SEL, 32'(`FCA_SEL_FCNT));
        wr(`FCA_ADR_EN, 32'h1);
        rd(`FCA_ADR_EN, 32'h1, "fcnt_en");
        for (int i = 0; i < 8; i++) wr(8'(`FCA_ADR_ROI + 4 * i), 32'h100 + i);
        $display("setup test done");
    endtask : t_setup

    task automatic t_swclr();
        wr(`FCA_ADR_CLR_CMD, 32'h1);
        rd(`FCA_ADR_FCNT, 32'h2, "fcnt_kept");
        wr(`FCA_ADR_CLR_ORG, 32'h3);
        rd(`FCA_ADR_CLR_ORG, 32'h0, "org_locked");
        wr(`FCA_ADR_SLOT, {28'h0, `FCA_EVT_FBEGIN, `FCA_SLOT_SECOND});
        wr(`FCA_ADR_CLR_ORG, 32'h3);
        rd(`FCA_ADR_CLR_ORG, 32'h3, "org_sw");
        wr(`FCA_ADR_CLR_CMD, 32'h1);
        rd(`FCA_ADR_FCNT, 32'h0, "fcnt_sw_clr");
        for (int o = 1; o <= 2; o++) begin
            wr(`FCA_ADR_CLR_ORG, o);
            t_frame(11, 32'h0);
            pulse(3 - o);
            rd(`FCA_ADR_FCNT, 32'h1, "fcnt_other_line");
            pulse(o);
            rd(`FCA_ADR_FCNT, 32'h0, "fcnt_line_clr");
        end
        $display("clear test done");
    endtask : t_swclr

    task automatic t_misc();
        logic [31:0] q;
        logic [31:0] fc;
        logic        e;
        pulse(3);
        rd(`FCA_ADR_TCNT, 32'h1, "tcnt_first");
        apb(1'b0, `FCA_ADR_TCNT, 32'h0, q, e);
        apb(1'b0, `FCA_ADR_FCNT, 32'h0, fc, e);
        check("trig_ahead", `FCA_CNT_ONE, q - fc);
        wr(`FCA_ADR_CTRL, 32'h0);
        rd(`FCA_ADR_PAYLOAD, 32'h0, "payload_off");
        rd(`FCA_ADR_EN, 32'h0, "en_off");
        t_frame(2, 32'h0);
        apb(1'b0, 8'h44, 32'h0, q, e);
        check("rd_err", 32'h1, e);
        check("rd_data", 32'h0, q);
        apb(1'b1, 8'h80, 32'h5, q, e);
        check("wr_err", 32'h1, e);
        $display("misc test done");
    endtask : t_misc

    initial begin
        {sys_rst, psel, penable, pwrite, slow, in_valid, in_last, trig_in, line1_in, line2_in} = 10'h200;
        paddr   = '0;
        pwdata  = 32'h0;
        in_data = 32'h0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_setup();
        t_frame(11, 32'h0);
        slow <= 1'b1;
        t_frame(11, 32'h1);
        slow <= 1'b0;
        t_swclr();
        t_misc();
        complete_run();
    end
endmodule : tb_fca_top

bind fca_top fca_monitor fca_monitor_i (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .in_valid, .in_ready, .in_last, .out_valid, .out_ready, .out_data, .out_last, .payload_kind);
